//--- rtl/cpuam_pkg.sv
package cpuam_pkg;
    localparam int AW = 16;
    localparam int DW = 8;
    localparam logic [1:0]  IMASK_SET   = 2'h3;
    localparam logic [1:0]  IMASK_CLR   = 2'h0;
    localparam logic [1:0]  IMASK_RST   = 2'h3;
    localparam logic [15:0] ONE16       = 16'h0001;
    localparam logic [7:0]  PAGE0_HI    = 8'h00;
    localparam logic [1:0]  LEN_NONE    = 2'h0;
    localparam logic [1:0]  LEN_BYTE    = 2'h1;
    localparam logic [1:0]  LEN_WORD    = 2'h2;

    typedef enum logic [3:0] {
        AM_INH   = 4'h0, AM_IMM   = 4'h1, AM_DIR_S = 4'h2, AM_DIR_L = 4'h3,
        AM_IDX_0 = 4'h4, AM_IDX_S = 4'h5, AM_IDX_L = 4'h6, AM_IND_S = 4'h7,
        AM_IND_L = 4'h8, AM_IIX_S = 4'h9, AM_IIX_L = 4'ha, AM_REL_D = 4'hb,
        AM_REL_I = 4'hc
    } cpuam_mode_t;

    typedef enum logic [2:0] {
        IOP_OTHER = 3'h0, IOP_SIM = 3'h1, IOP_RIM = 3'h2,
        IOP_WFI   = 3'h3, IOP_HALT = 3'h4
    } cpuam_iop_t;

    // operand bytes that follow the opcode, prebyte not counted
    function automatic logic [1:0] am_len(input cpuam_mode_t m);
        case (m)
            AM_INH, AM_IDX_0:     am_len = LEN_NONE;
            AM_DIR_L, AM_IDX_L:   am_len = LEN_WORD;
            default:              am_len = LEN_BYTE;
        endcase
    endfunction

    function automatic logic am_long(input cpuam_mode_t m);
        am_long = (m == AM_DIR_L) || (m == AM_IDX_L) || (m == AM_IND_L) || (m == AM_IIX_L);
    endfunction

    function automatic logic am_ptr(input cpuam_mode_t m);
        am_ptr = (m == AM_IND_S) || (m == AM_IND_L) || (m == AM_IIX_S) || (m == AM_IIX_L)
              || (m == AM_REL_I);
    endfunction

    function automatic logic am_ptr_word(input cpuam_mode_t m);
        am_ptr_word = (m == AM_IND_L) || (m == AM_IIX_L);
    endfunction

    function automatic logic am_idx(input cpuam_mode_t m);
        am_idx = (m == AM_IDX_0) || (m == AM_IDX_S) || (m == AM_IDX_L)
              || (m == AM_IIX_S) || (m == AM_IIX_L);
    endfunction
endpackage

//--- rtl/cpuam_ea.sv
module cpuam_ea
    import cpuam_pkg::*;
(
    // clock
    input  wire logic          sys_clk_i,
    input  wire logic          sys_rst_i,
    input  wire logic          ce_i,
    // operands
    input  wire logic          go_i,
    input  wire logic [AW-1:0] base_i,
    input  wire logic [DW-1:0] off_i,
    input  wire logic          add_i,
    input  wire logic          sgn_i,
    // result
    output logic      [AW-1:0] sum_o
);
    logic [AW-1:0] sum_d;
    logic [AW-1:0] ext;

    always_comb begin
        // byte widened before the add so short sums carry into bit 8
        ext = {PAGE0_HI, off_i};
        if (sgn_i) begin
            ext = {{(AW-DW){off_i[DW-1]}}, off_i};
        end
        sum_d = sum_o;
        if (go_i) begin
            sum_d = add_i ? base_i + ext : base_i;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            sum_o <= '0;
        end else if (ce_i) begin
            sum_o <= sum_d;
        end
    end
endmodule // cpuam_ea

//--- rtl/cpuam_lpctl.sv
module cpuam_lpctl
    import cpuam_pkg::*;
(
    // clock
    input  wire logic       sys_clk_i,
    input  wire logic       sys_rst_i,
    input  wire logic       ce_i,
    // inherent execution
    input  wire logic       exec_i,
    input  wire cpuam_iop_t iop_i,
    input  wire logic       irq_pend_i,
    input  wire logic       wake_pin_i,
    // state
    output logic [1:0]      irq_mask_o,
    output logic            wait_o,
    output logic            halt_o
);
    logic [1:0] mask_d;
    logic       wait_d;
    logic       halt_d;
    logic       wk_s1_q;
    logic       wk_s2_q;

    always_comb begin
        mask_d = irq_mask_o;
        wait_d = wait_o;
        halt_d = halt_o;
        if (wait_o && irq_pend_i) begin
            wait_d = 1'b0;
        end
        if (halt_o && wk_s2_q) begin
            halt_d = 1'b0;
        end
        if (exec_i) begin
            case (iop_i)
                IOP_SIM:  mask_d = IMASK_SET;
                IOP_RIM:  mask_d = IMASK_CLR;
                IOP_WFI:  wait_d = 1'b1;
                IOP_HALT: halt_d = 1'b1;
                default:  mask_d = irq_mask_o;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            irq_mask_o <= IMASK_RST;
            wait_o     <= 1'b0;
            halt_o     <= 1'b0;
            wk_s1_q    <= 1'b0;
            wk_s2_q    <= 1'b0;
        end else if (ce_i) begin
            irq_mask_o <= mask_d;
            wait_o     <= wait_d;
            halt_o     <= halt_d;
            wk_s1_q    <= wake_pin_i;
            wk_s2_q    <= wk_s1_q;
        end
    end
endmodule // cpuam_lpctl

//--- rtl/cpuam_dec.sv
module cpuam_dec
    import cpuam_pkg::*;
(
    // clock and reset
    input  wire logic          sys_clk_i,
    input  wire logic          sys_rst_i,
    input  wire logic          ce_i,
    // instruction request
    input  wire logic          start_i,
    input  wire cpuam_mode_t   mode_i,
    input  wire cpuam_iop_t    iop_i,
    input  wire logic          m2m_i,
    input  wire logic          idx_y_i,
    input  wire logic [AW-1:0] pc_i,
    input  wire logic [DW-1:0] x_i,
    input  wire logic [DW-1:0] y_i,
    // memory read port
    input  wire logic          mem_ack_i,
    input  wire logic [DW-1:0] mem_rdata_i,
    output logic               mem_rd_o,
    output logic      [AW-1:0] mem_addr_o,
    // result
    output logic               ready_o,
    output logic               done_o,
    output logic               err_o,
    output logic      [AW-1:0] ea_o,
    output logic      [DW-1:0] operand_o,
    output logic               imm_o,
    output logic      [1:0]    len_o,
    // core state
    input  wire logic          irq_pend_i,
    input  wire logic          wake_pin_i,
    output logic      [1:0]    irq_mask_o,
    output logic               wait_o,
    output logic               halt_o
);
    typedef enum logic [6:0] {
        ST_IDLE = 7'b0000001,
        ST_OPB1 = 7'b0000010,
        ST_OPB2 = 7'b0000100,
        ST_PTR1 = 7'b0001000,
        ST_PTR2 = 7'b0010000,
        ST_CALC = 7'b0100000,
        ST_DONE = 7'b1000000
    } cpuam_st_t;

    cpuam_st_t     st_q, st_d;
    cpuam_mode_t   mode_q, mode_d;
    logic [DW-1:0] idx_q, idx_d;
    logic [AW-1:0] pc_q, pc_d;
    logic [DW-1:0] b1_q, b1_d;
    logic [DW-1:0] b2_q, b2_d;
    logic [DW-1:0] ph_q, ph_d;
    logic [DW-1:0] pl_q, pl_d;
    logic          rd_q, rd_d;
    logic [AW-1:0] ad_q, ad_d;
    logic          rdy_q, rdy_d;
    logic          done_q, done_d;
    logic          err_q, err_d;
    logic [AW-1:0] ea_q, ea_d;
    logic [DW-1:0] opnd_q, opnd_d;
    logic          imm_q, imm_d;
    logic [1:0]    len_q, len_d;
    logic          exec;
    logic          go;
    logic [AW-1:0] base;
    logic [DW-1:0] off;
    logic          add;
    logic          sgn;
    logic [AW-1:0] sum;
    logic [AW-1:0] pc_end;
    logic          lp_wait;
    logic          lp_halt;
    logic          take;

    // start is ignored while busy or in a low-power state
    assign take = start_i && rdy_q;
    assign pc_end = pc_q + ONE16 + {14'h0000, am_len(mode_q)};

    always_comb begin
        st_d   = st_q;
        mode_d = mode_q;
        idx_d  = idx_q;
        pc_d   = pc_q;
        b1_d   = b1_q;
        b2_d   = b2_q;
        ph_d   = ph_q;
        pl_d   = pl_q;
        rd_d   = rd_q;
        ad_d   = ad_q;
        done_d = 1'b0;
        err_d  = 1'b0;
        ea_d   = ea_q;
        opnd_d = opnd_q;
        imm_d  = imm_q;
        len_d  = len_q;
        exec   = 1'b0;
        go     = 1'b0;
        case (st_q)
            ST_IDLE: begin
                if (take) begin
                    mode_d = mode_i;
                    idx_d  = idx_y_i ? y_i : x_i;
                    pc_d   = pc_i;
                    b1_d   = '0;
                    b2_d   = '0;
                    ph_d   = '0;
                    pl_d   = '0;
                    if (m2m_i && am_long(mode_i)) begin
                        // long forms refused for read-modify-write ops
                        err_d = 1'b1;
                    end else if (mode_i == AM_INH) begin
                        exec   = 1'b1;
                        len_d  = LEN_NONE;
                        ea_d   = '0;
                        opnd_d = '0;
                        imm_d  = 1'b0;
                        done_d = 1'b1;
                    end else if (am_len(mode_i) == LEN_NONE) begin
                        st_d = ST_CALC;
                    end else begin
                        rd_d = 1'b1;
                        ad_d = pc_i + ONE16;
                        st_d = ST_OPB1;
                    end
                end
            end
            ST_OPB1: begin
                if (mem_ack_i) begin
                    b1_d = mem_rdata_i;
                    if (am_len(mode_q) == LEN_WORD) begin
                        ad_d = ad_q + ONE16;
                        st_d = ST_OPB2;
                    end else if (am_ptr(mode_q)) begin
                        // pointer always starts in page zero; a word pointer at 00ff reads its second byte from 0100
                        ad_d = {PAGE0_HI, mem_rdata_i};
                        st_d = ST_PTR1;
                    end else begin
                        rd_d = 1'b0;
                        st_d = ST_CALC;
                    end
                end
            end
            ST_OPB2: begin
                if (mem_ack_i) begin
                    b2_d = mem_rdata_i;
                    rd_d = 1'b0;
                    st_d = ST_CALC;
                end
            end
            ST_PTR1: begin
                if (mem_ack_i) begin
                    if (am_ptr_word(mode_q)) begin
                        ph_d = mem_rdata_i;
                        ad_d = ad_q + ONE16;
                        st_d = ST_PTR2;
                    end else begin
                        pl_d = mem_rdata_i;
                        rd_d = 1'b0;
                        st_d = ST_CALC;
                    end
                end
            end
            ST_PTR2: begin
                if (mem_ack_i) begin
                    pl_d = mem_rdata_i;
                    rd_d = 1'b0;
                    st_d = ST_CALC;
                end
            end
            ST_CALC: begin
                go   = 1'b1;
                st_d = ST_DONE;
            end
            ST_DONE: begin
                ea_d   = sum;
                imm_d  = (mode_q == AM_IMM);
                opnd_d = (mode_q == AM_IMM) ? b1_q : '0;
                len_d  = am_len(mode_q);
                done_d = 1'b1;
                st_d   = ST_IDLE;
            end
            default: begin
                rd_d = 1'b0;
                st_d = ST_IDLE;
            end
        endcase
        rdy_d = (st_d == ST_IDLE) && !lp_wait && !lp_halt && !exec;
    end

    // base, offset and kind of addition for the result adder
    always_comb begin
        base = '0;
        off  = idx_q;
        add  = am_idx(mode_q);
        sgn  = 1'b0;
        case (mode_q)
            AM_IMM:   base = pc_q + ONE16;
            AM_DIR_S: base = {PAGE0_HI, b1_q};
            AM_DIR_L: base = {b1_q, b2_q};
            AM_IDX_0: base = '0;
            AM_IDX_S: base = {PAGE0_HI, b1_q};
            AM_IDX_L: base = {b1_q, b2_q};
            AM_IND_S: base = {PAGE0_HI, pl_q};
            AM_IND_L: base = {ph_q, pl_q};
            AM_IIX_S: base = {PAGE0_HI, pl_q};
            AM_IIX_L: base = {ph_q, pl_q};
            AM_REL_D: begin
                base = pc_end;
                off  = b1_q;
                add  = 1'b1;
                sgn  = 1'b1;
            end
            AM_REL_I: begin
                base = pc_end;
                off  = pl_q;
                add  = 1'b1;
                sgn  = 1'b1;
            end
            default: base = '0;
        endcase
    end

    cpuam_ea u_ea (
        .sys_clk_i (sys_clk_i),
        .sys_rst_i (sys_rst_i),
        .ce_i      (ce_i),
        .go_i      (go),
        .base_i    (base),
        .off_i     (off),
        .add_i     (add),
        .sgn_i     (sgn),
        .sum_o     (sum)
    );

    cpuam_lpctl u_lp (
        .sys_clk_i  (sys_clk_i),
        .sys_rst_i  (sys_rst_i),
        .ce_i       (ce_i),
        .exec_i     (exec),
        .iop_i      (iop_i),
        .irq_pend_i (irq_pend_i),
        .wake_pin_i (wake_pin_i),
        .irq_mask_o (irq_mask_o),
        .wait_o     (lp_wait),
        .halt_o     (lp_halt)
    );

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            st_q   <= ST_IDLE;
            mode_q <= AM_INH;
            idx_q  <= '0;
            pc_q   <= '0;
            b1_q   <= '0;
            b2_q   <= '0;
            ph_q   <= '0;
            pl_q   <= '0;
            rd_q   <= 1'b0;
            ad_q   <= '0;
            rdy_q  <= 1'b0;
            done_q <= 1'b0;
            err_q  <= 1'b0;
            ea_q   <= '0;
            opnd_q <= '0;
            imm_q  <= 1'b0;
            len_q  <= LEN_NONE;
        end else if (ce_i) begin
            st_q   <= st_d;
            mode_q <= mode_d;
            idx_q  <= idx_d;
            pc_q   <= pc_d;
            b1_q   <= b1_d;
            b2_q   <= b2_d;
            ph_q   <= ph_d;
            pl_q   <= pl_d;
            rd_q   <= rd_d;
            ad_q   <= ad_d;
            rdy_q  <= rdy_d;
            done_q <= done_d;
            err_q  <= err_d;
            ea_q   <= ea_d;
            opnd_q <= opnd_d;
            imm_q  <= imm_d;
            len_q  <= len_d;
        end
    end

    assign mem_rd_o   = rd_q;
    assign mem_addr_o = ad_q;
    assign ready_o    = rdy_q;
    assign done_o     = done_q;
    assign err_o      = err_q;
    assign ea_o       = ea_q;
    assign operand_o  = opnd_q;
    assign imm_o      = imm_q;
    assign len_o      = len_q;
    assign wait_o     = lp_wait;
    assign halt_o     = lp_halt;
endmodule // cpuam_dec

//--- tb/cpuam_mem.sv
module cpuam_mem
    import cpuam_pkg::*;
(
    // clock
    input  wire logic          sys_clk_i,
    input  wire logic          sys_rst_i,
    // read port
    input  wire logic          rd_i,
    input  wire logic [AW-1:0] addr_i,
    input  wire logic [3:0]    lat_i,
    output logic               ack_o,
    output logic      [DW-1:0] data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt;

    function automatic logic [DW-1:0] mb(input logic [AW-1:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5a;
    endfunction

    // data lines drift to the inverse once the ack cycle is over
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            ack_o  <= 1'b0;
            cnt    <= 4'h0;
            data_o <= 8'h00;
        end else if (ack_o) begin
            ack_o  <= 1'b0;
            cnt    <= 4'h0;
            data_o <= ~data_o;
        end else if (rd_i) begin
            if (cnt == lat_i) begin
                ack_o  <= 1'b1;
                data_o <= mb(addr_i);
            end else begin
                cnt <= cnt + 4'h1;
            end
        end
    end
endmodule // cpuam_mem

//--- tb/cpuam_dec_sva.sv
module cpuam_dec_chk
    import cpuam_pkg::*;
(
    // watched ports
    input wire logic          sys_clk_i,
    input wire logic          sys_rst_i,
    input wire logic          ce_i,
    input wire logic          start_i,
    input wire cpuam_mode_t   mode_i,
    input wire cpuam_iop_t    iop_i,
    input wire logic          m2m_i,
    input wire logic          idx_y_i,
    input wire logic [AW-1:0] pc_i,
    input wire logic [DW-1:0] x_i,
    input wire logic [DW-1:0] y_i,
    input wire logic          mem_ack_i,
    input wire logic          mem_rd_o,
    input wire logic [AW-1:0] mem_addr_o,
    input wire logic          ready_o,
    input wire logic          done_o,
    input wire logic          err_o,
    input wire logic [AW-1:0] ea_o,
    input wire logic [1:0]    len_o,
    input wire logic          wake_pin_i,
    input wire logic          irq_pend_i,
    input wire logic [1:0]    irq_mask_o,
    input wire logic          wait_o,
    input wire logic          halt_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic take;
    logic lng;
    assign take = ce_i && start_i && ready_o;
    assign lng  = mode_i inside {AM_DIR_L, AM_IDX_L, AM_IND_L, AM_IIX_L};

    default clocking cb @(posedge sys_clk_i); endclocking
    // a frozen clock enable stretches every sequence, so attempts then are dropped
    default disable iff (sys_rst_i || !ce_i);

    a_inh_one_byte: assert property (take && mode_i == AM_INH |=> done_o && len_o == LEN_NONE && !mem_rd_o)
        else $error("inherent op not done in one cycle");
    a_first_fetch: assert property (take && !(mode_i inside {AM_INH, AM_IDX_0}) && !(m2m_i && lng)
        |=> mem_rd_o && mem_addr_o == $past(pc_i) + ONE16)
        else $error("first operand read not at opcode plus one");
    a_idx0_no_fetch: assert property (take && mode_i == AM_IDX_0 |-> ##1 !mem_rd_o ##1 !mem_rd_o
        ##1 (done_o && ea_o == {8'h00, $past(idx_y_i, 3) ? $past(y_i, 3) : $past(x_i, 3)}))
        else $error("no-offset index result wrong");
    a_m2m_long_err: assert property (take && m2m_i && lng |=> err_o && !done_o && !mem_rd_o)
        else $error("long mode not refused for memory op");
    a_set_mask: assert property (take && mode_i == AM_INH && iop_i == IOP_SIM |-> ##2 irq_mask_o == IMASK_SET)
        else $error("mask not raised to 3");
    a_clr_mask: assert property (take && mode_i == AM_INH && iop_i == IOP_RIM |-> ##2 irq_mask_o == IMASK_CLR)
        else $error("mask not lowered to 0");
    a_wait_entry: assert property (take && mode_i == AM_INH && iop_i == IOP_WFI |-> ##2 wait_o && !ready_o)
        else $error("wait state not entered");
    a_wait_wake: assert property (wait_o && irq_pend_i |-> ##[1:2] !wait_o)
        else $error("wait state not left on interrupt");
    a_halt_wake: assert property ($rose(wake_pin_i) && halt_o |-> ##[1:6] !halt_o)
        else $error("halt not left on wake pin");
    a_read_hold: assert property (mem_rd_o && !mem_ack_i |=> mem_rd_o && $stable(mem_addr_o))
        else $error("read request dropped before ack");

    c_done: cover property (done_o && len_o == LEN_WORD);
    c_err: cover property (err_o);
    c_halt: cover property (halt_o);
endmodule // cpuam_dec_chk

bind cpuam_dec cpuam_dec_chk u_chk (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i), .start_i(start_i), .mode_i(mode_i),
    .iop_i(iop_i), .m2m_i(m2m_i), .idx_y_i(idx_y_i), .pc_i(pc_i), .x_i(x_i), .y_i(y_i),
    .mem_ack_i(mem_ack_i), .mem_rd_o(mem_rd_o), .mem_addr_o(mem_addr_o), .ready_o(ready_o),
    .done_o(done_o), .err_o(err_o), .ea_o(ea_o), .len_o(len_o), .wake_pin_i(wake_pin_i),
    .irq_pend_i(irq_pend_i), .irq_mask_o(irq_mask_o), .wait_o(wait_o), .halt_o(halt_o)
);

//--- tb/test_cpuam_dec.sv
module test_cpuam_dec;
    timeunit 1ns;
    timeprecision 1ps;
    import cpuam_pkg::*;

    logic          sys_clk_i = 1'b0, sys_rst_i = 1'b1, start_i = 1'b0, m2m_i = 1'b0, idx_y_i = 1'b0;
    logic          irq_pend_i = 1'b0, wake_pin_i = 1'b0, ce_i = 1'b1;
    cpuam_mode_t   mode_i = AM_INH;
    cpuam_iop_t    iop_i = IOP_OTHER;
    logic [AW-1:0] pc_i = 16'h0000, mem_addr_o, ea_o;
    logic [DW-1:0] x_i = 8'h00, y_i = 8'h00, mem_rdata_i, operand_o;
    logic          mem_ack_i, mem_rd_o, ready_o, done_o, err_o, imm_o, wait_o, halt_o;
    logic [1:0]    len_o, irq_mask_o;
    logic [3:0]    lat = 4'h0;
    int            error_cnt = 0;
    int            num_checks = 0;

    always #2 sys_clk_i = ~sys_clk_i;

    cpuam_dec uut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i), .start_i(start_i),
        .mode_i(mode_i), .iop_i(iop_i), .m2m_i(m2m_i), .idx_y_i(idx_y_i), .pc_i(pc_i), .x_i(x_i),
        .y_i(y_i), .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i), .mem_rd_o(mem_rd_o),
        .mem_addr_o(mem_addr_o), .ready_o(ready_o), .done_o(done_o), .err_o(err_o), .ea_o(ea_o),
        .operand_o(operand_o), .imm_o(imm_o), .len_o(len_o), .irq_pend_i(irq_pend_i),
        .wake_pin_i(wake_pin_i), .irq_mask_o(irq_mask_o), .wait_o(wait_o), .halt_o(halt_o));
    cpuam_mem u_mem (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .rd_i(mem_rd_o), .addr_i(mem_addr_o),
        .lat_i(lat), .ack_o(mem_ack_i), .data_o(mem_rdata_i));

    function automatic logic [7:0] mb(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5a;
    endfunction

    function automatic logic [15:0] exp_ea(input cpuam_mode_t m, input logic [15:0] pc, input logic [7:0] ix);
        logic [15:0] w, p, ps, pw, ixw;
        w   = {mb(pc + 16'h0001), mb(pc + 16'h0002)};
        p   = {8'h00, w[15:8]};
        ps  = {8'h00, mb(p)};
        pw  = {mb(p), mb(p + 16'h0001)};
        ixw = {8'h00, ix};
        case (m)
            AM_IMM:   return pc + 16'h0001;
            AM_DIR_S: return p;
            AM_DIR_L: return w;
            AM_IDX_0: return ixw;
            AM_IDX_S: return p + ixw;
            AM_IDX_L: return w + ixw;
            AM_IND_S: return ps;
            AM_IND_L: return pw;
            AM_IIX_S: return ps + ixw;
            AM_IIX_L: return pw + ixw;
            AM_REL_D: return pc + 16'h0002 + {{8{w[15]}}, w[15:8]};
            default:  return pc + 16'h0002 + {{8{ps[7]}}, ps[7:0]};
        endcase
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wrap_up();
        $display("checks=%0d errors=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // returns at the falling edge where done or err shows
    task automatic op(input cpuam_mode_t m, input cpuam_iop_t io, input logic mm, input logic iy,
                      input logic [15:0] pc, input logic [7:0] x, input logic [7:0] y);
        int i;
        // one edge between requests, so start never rises where it just fell
        @(negedge sys_clk_i);
        for (i = 0; i < 100 && ready_o !== 1'b1; i++) @(negedge sys_clk_i);
        mode_i = m;
        iop_i = io;
        m2m_i = mm;
        idx_y_i = iy;
        pc_i = pc;
        x_i = x;
        y_i = y;
        start_i = 1'b1;
        @(negedge sys_clk_i);
        start_i = 1'b0;
        for (i = 0; i < 200 && done_o !== 1'b1 && err_o !== 1'b1; i++) @(negedge sys_clk_i);
    endtask

    // other index register holds the complement so a swapped select shows
    task automatic sc_mode(input cpuam_mode_t m, input logic [15:0] pc, input logic iy, input logic [7:0] ix);
        logic [1:0] el;
        el = (m == AM_IDX_0) ? LEN_NONE : (m == AM_DIR_L || m == AM_IDX_L) ? LEN_WORD : LEN_BYTE;
        op(m, IOP_OTHER, 1'b0, iy, pc, iy ? ~ix : ix, iy ? ix : ~ix);
        chk(done_o, 16'h0001);
        chk(ea_o, exp_ea(m, pc, ix));
        chk(len_o, el);
        chk(imm_o, m == AM_IMM);
        chk(operand_o, m == AM_IMM ? mb(pc + 16'h0001) : 8'h00);
    endtask

    // clock enable low holds a decode part way, then it must finish
    task automatic sc_freeze();
        int i;
        @(negedge sys_clk_i);
        for (i = 0; i < 100 && ready_o !== 1'b1; i++) @(negedge sys_clk_i);
        mode_i = AM_IDX_0;
        m2m_i = 1'b0;
        idx_y_i = 1'b1;
        y_i = 8'h5c;
        start_i = 1'b1;
        @(negedge sys_clk_i);
        start_i = 1'b0;
        ce_i = 1'b0;
        repeat (6) @(negedge sys_clk_i);
        chk({done_o, ready_o, mem_rd_o}, 16'h0000);
        ce_i = 1'b1;
        for (i = 0; i < 10 && done_o !== 1'b1; i++) @(negedge sys_clk_i);
        chk(ea_o, 16'h005c);
    endtask

    task automatic sc_all_modes();
        for (int k = 1; k < 13; k++) sc_mode(cpuam_mode_t'(k[3:0]), 16'h00a4, k[0], 8'h33);
        lat = 4'h3;
        for (int k = 1; k < 13; k++) sc_mode(cpuam_mode_t'(k[3:0]), 16'h3c10, k[1], 8'h81);
        lat = 4'h0;
    endtask

    task automatic sc_boundary();
        sc_mode(AM_IDX_S, 16'h00a4, 1'b0, 8'hff);
        sc_mode(AM_IIX_S, 16'h00fe, 1'b1, 8'hff);
        sc_mode(AM_IDX_L, 16'h00a4, 1'b1, 8'hff);
        sc_mode(AM_IND_L, 16'h00a4, 1'b0, 8'h00);
        sc_mode(AM_IIX_L, 16'h00a4, 1'b1, 8'hf0);
    endtask

    task automatic sc_m2m();
        cpuam_mode_t lm[4] = '{AM_DIR_L, AM_IDX_L, AM_IND_L, AM_IIX_L};
        logic [15:0] prev;
        foreach (lm[k]) begin
            prev = ea_o;
            op(lm[k], IOP_OTHER, 1'b1, 1'b0, 16'h2000, 8'h12, 8'h34);
            chk({err_o, done_o, mem_rd_o}, 16'h0004);
            chk(ea_o, prev);
        end
        op(AM_DIR_S, IOP_OTHER, 1'b1, 1'b0, 16'h2000, 8'h12, 8'h34);
        chk(ea_o, {8'h00, mb(16'h2001)});
    endtask

    task automatic sc_inherent();
        int i;
        op(AM_INH, IOP_OTHER, 1'b0, 1'b0, 16'h0400, 8'h00, 8'h00);
        chk({done_o, len_o, mem_rd_o}, 16'h0008);
        op(AM_INH, IOP_RIM, 1'b0, 1'b0, 16'h0401, 8'h00, 8'h00);
        @(negedge sys_clk_i);
        chk(irq_mask_o, IMASK_CLR);
        op(AM_INH, IOP_SIM, 1'b0, 1'b0, 16'h0402, 8'h00, 8'h00);
        @(negedge sys_clk_i);
        chk(irq_mask_o, IMASK_SET);
        op(AM_INH, IOP_WFI, 1'b0, 1'b0, 16'h0403, 8'h00, 8'h00);
        repeat (3) @(negedge sys_clk_i);
        chk({wait_o, ready_o}, 16'h0002);
        irq_pend_i = 1'b1;
        for (i = 0; i < 10 && wait_o !== 1'b0; i++) @(negedge sys_clk_i);
        irq_pend_i = 1'b0;
        chk(wait_o, 16'h0000);
        op(AM_INH, IOP_HALT, 1'b0, 1'b0, 16'h0404, 8'h00, 8'h00);
        repeat (3) @(negedge sys_clk_i);
        chk({halt_o, ready_o}, 16'h0002);
        wake_pin_i = 1'b1;
        for (i = 0; i < 10 && halt_o !== 1'b0; i++) @(negedge sys_clk_i);
        wake_pin_i = 1'b0;
        chk(halt_o, 16'h0000);
    endtask

    initial begin
        repeat (16) @(negedge sys_clk_i);
        sys_rst_i = 1'b0;
        repeat (2) @(negedge sys_clk_i);
        chk(irq_mask_o, IMASK_RST);
        sc_all_modes();
        sc_boundary();
        sc_m2m();
        sc_inherent();
        sc_freeze();
        repeat (4) @(negedge sys_clk_i);
        wrap_up();
    end

    // whole run needs a few hundred cycles at most
    initial begin
        #80000;
        error_cnt++;
        wrap_up();
    end
endmodule // test_cpuam_dec
